// File: slp_pkg.sv
// Purpose: Shared constants for the strap latch and port mapping block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: All offsets are byte addresses.
package slp_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CHARGE = 8'h04;
  localparam logic [7:0] OFS_HOSTCFG = 8'h08;
  localparam logic [7:0] OFS_PINOUT = 8'h0c;
  localparam logic [7:0] OFS_PORTS = 8'h10;

  // ==========================================================
  // Strap pin positions and widths
  localparam int STRAP_W = 6;
  localparam int STRAP_MODE = 0;
  localparam int STRAP_SWAP = 1;
  localparam int STRAP_CHG_LSB = 2;
  localparam int PORT_W = 5;
  localparam int LOG_W = 3;

  // ==========================================================
  // Field positions
  localparam int ST_MODE = 0;
  localparam int ST_SWAP = 1;
  localparam int ST_HOST = 2;
  localparam int ST_VALID = 3;
  localparam int HC_MODE = 0;
  localparam int HC_SWAP = 1;
  localparam int PS_UP_LSB = 0;
  localparam int PS_EN_LSB = 5;
  localparam int PS_OCS_LSB = 10;
  localparam int PS_DCNT_LSB = 16;

  // ==========================================================
  // Reset values and topology figures
  localparam logic [4:0] CHARGE_RST = 5'h00;
  localparam logic [1:0] HOSTCFG_RST = 2'h0;
  localparam logic [5:0] PINOUT_RST = 6'h00;
  localparam logic [2:0] DCNT_ONE_UP = 3'h4;
  localparam logic [2:0] DCNT_TWO_UP = 3'h3;

  typedef enum logic [0:0]
  {
    SLP_HOLD = 1'b0,
    SLP_RUN = 1'b1
  } slp_state_e;

endpackage

// File: slp_strap_latch.sv
// Purpose: Latches configuration straps at reset release and derives the
//   port topology, port roles and per-port charge enables.
// Assumes: All inputs synchronous to clk_i; strap pins are six signals.
// Notes: Registers are reached over APB.
// Overview of operation
// RULE1: Strap pins undriven while power-on or external reset is active.
// RULE2: On reset release, strap levels are captured as feature defaults.
// RULE3: After capture, strap pins are driven as normal outputs.
// RULE4: Board only pulls straps with resistors, never drives them.
// RULE5: Topology strap 0 means one up four down, 1 two up three down.
// RULE6: One-up mode: swap 0 port 0 upstream, swap 1 port 1 upstream.
// RULE7: One-up mode with swap low gives standard four downstream ports.
// RULE8: One-up swapped mode: no overcurrent sensing on physical port 0.
// RULE9: Two-up mode: the non-upstream port of ports 0 and 1 is disabled.
// RULE10: Physical ports 2, 3, 4 appear as logical ports 1, 2, 3.
// RULE11: Four charge straps high at capture advertise charging support.
// RULE12: Both serial lines high at capture: straps ignored, host config used.
// RULE13: Charge enable register bit 1 maps to downstream port 1, upward.
// RULE14: Captured values hold until the next reset release recaptures.
`timescale 1ns/100ps

module slp_strap_latch
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic por_i,
  input wire logic ext_rst_n_i,
  input wire logic cfg_sda_i,
  input wire logic cfg_scl_i,
  input wire logic [5:0] strap_in_i,
  output logic [5:0] strap_out_o,
  output logic [5:0] strap_oe_o,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  output logic [4:0] port_upstream_o,
  output logic [4:0] port_enable_o,
  output logic [4:0] overcurrent_sense_en_o,
  output logic [2:0] downstream_count_o,
  output logic [8:0] logical_port_phys_o,
  output logic [4:1] charge_advertise_o,
  output logic config_valid_o
);

  // ==========================================================
  // Helpers

  function automatic logic [2:0] phys_of_logical(input int idx);
    phys_of_logical = 3'(idx + 2);
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == slp_pkg::OFS_STATUS) ||
              (a == slp_pkg::OFS_CHARGE) ||
              (a == slp_pkg::OFS_HOSTCFG) ||
              (a == slp_pkg::OFS_PINOUT) ||
              (a == slp_pkg::OFS_PORTS);
  endfunction

  // ==========================================================
  // Strap state

  slp_pkg::slp_state_e state;
  logic hold;
  logic cap_mode;
  logic cap_swap;
  logic cap_host;
  logic cap_valid;
  logic [4:0] charge;
  logic [1:0] host_cfg;
  logic [5:0] pin_out;
  logic eff_mode;
  logic eff_swap;
  logic acc;
  logic wr;
  logic [4:0] next_up;
  logic [4:0] next_en;
  logic [4:0] next_ocs;
  logic [31:0] rd_val;

  assign hold = por_i | ~ext_rst_n_i;
  assign acc = psel_i & penable_i & pready_o;
  assign wr = acc & pwrite_i;

  // RULE1: undrive while held.
  // RULE3: drive once captured.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= slp_pkg::SLP_HOLD;
      strap_oe_o <= 6'h00;
    end
    else
    begin
      case (state)
        slp_pkg::SLP_HOLD:
        begin
          if (!hold)
          begin
            state <= slp_pkg::SLP_RUN;
            strap_oe_o <= 6'h3f;
          end
        end
        slp_pkg::SLP_RUN:
        begin
          if (hold)
          begin
            state <= slp_pkg::SLP_HOLD;
            strap_oe_o <= 6'h00;
          end
        end
        default:
        begin
          state <= slp_pkg::SLP_HOLD;
          strap_oe_o <= 6'h00;
        end
      endcase
    end
  end

  // Pins are still undriven in the capture cycle, so the board level
  // is what gets sampled, not our own output.
  // RULE2: capture on release.
  // RULE5: topology strap.
  // RULE12: serial lines select host config.
  // RULE14: hold until recapture.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cap_mode <= 1'b0;
      cap_swap <= 1'b0;
      cap_host <= 1'b0;
      cap_valid <= 1'b0;
    end
    else if (state == slp_pkg::SLP_HOLD && !hold)
    begin
      cap_mode <= strap_in_i[slp_pkg::STRAP_MODE];
      cap_swap <= strap_in_i[slp_pkg::STRAP_SWAP];
      cap_host <= cfg_sda_i & cfg_scl_i;
      cap_valid <= 1'b1;
    end
    else if (hold)
    begin
      cap_valid <= 1'b0;
    end
  end

  // RULE11: charge straps load defaults.
  // RULE13: bit n is downstream port n.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      charge <= slp_pkg::CHARGE_RST;
    end
    else if (state == slp_pkg::SLP_HOLD && !hold)
    begin
      if (cfg_sda_i & cfg_scl_i)
      begin
        charge <= slp_pkg::CHARGE_RST;
      end
      else
      begin
        charge <= {strap_in_i[slp_pkg::STRAP_CHG_LSB +: 4], 1'b0};
      end
    end
    else if (wr && paddr_i == slp_pkg::OFS_CHARGE)
    begin
      charge <= {pwdata_i[4:1], 1'b0};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      host_cfg <= slp_pkg::HOSTCFG_RST;
    end
    else if (wr && paddr_i == slp_pkg::OFS_HOSTCFG)
    begin
      host_cfg <= pwdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_out <= slp_pkg::PINOUT_RST;
    end
    else if (wr && paddr_i == slp_pkg::OFS_PINOUT)
    begin
      pin_out <= pwdata_i[5:0];
    end
  end

  // RULE3: functional output value.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      strap_out_o <= slp_pkg::PINOUT_RST;
    end
    else
    begin
      strap_out_o <= pin_out;
    end
  end

  // ==========================================================
  // Port roles

  // RULE12: host settings replace straps.
  assign eff_mode = cap_host ? host_cfg[slp_pkg::HC_MODE] : cap_mode;
  assign eff_swap = cap_host ? host_cfg[slp_pkg::HC_SWAP] : cap_swap;

  always_comb
  begin
    next_up = 5'h00;
    next_en = 5'h1c;
    next_ocs = 5'h1c;
    // RULE6: swap picks the upstream port.
    next_up[0] = ~eff_swap;
    next_up[1] = eff_swap;
    if (eff_mode)
    begin
      // RULE9: the other port is disabled.
      next_en[0] = ~eff_swap;
      next_en[1] = eff_swap;
    end
    else
    begin
      // RULE7: swap low is a plain hub.
      next_en[0] = 1'b1;
      next_en[1] = 1'b1;
      next_ocs[1] = ~eff_swap;
      // RULE8: no sensing on swapped port 0.
      next_ocs[0] = 1'b0;
    end
    if (!cap_valid)
    begin
      next_en = 5'h00;
      next_ocs = 5'h00;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      port_upstream_o <= 5'h00;
      port_enable_o <= 5'h00;
      overcurrent_sense_en_o <= 5'h00;
      downstream_count_o <= 3'h0;
      config_valid_o <= 1'b0;
    end
    else
    begin
      port_upstream_o <= next_up;
      port_enable_o <= next_en;
      overcurrent_sense_en_o <= next_ocs;
      // RULE5: downstream count per topology.
      downstream_count_o <= eff_mode ? slp_pkg::DCNT_TWO_UP :
                            slp_pkg::DCNT_ONE_UP;
      config_valid_o <= cap_valid;
    end
  end

  // RULE11: advertise only once captured.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      charge_advertise_o <= 4'h0;
    end
    else
    begin
      charge_advertise_o <= cap_valid ? charge[4:1] : 4'h0;
    end
  end

  // The mapping is fixed, but registering it keeps every output a flop.
  genvar gi;
  generate
    for (gi = 0; gi < slp_pkg::LOG_W; gi++)
    begin : g_map
      // RULE10: physical n+1 is logical n.
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          logical_port_phys_o[gi*3 +: 3] <= 3'h0;
        end
        else
        begin
          logical_port_phys_o[gi*3 +: 3] <= phys_of_logical(gi);
        end
      end
    end
  endgenerate

  // ==========================================================
  // APB slave

  always_comb
  begin
    rd_val = 32'h0;
    case (paddr_i)
      slp_pkg::OFS_STATUS:
      begin
        rd_val[slp_pkg::ST_MODE] = cap_mode;
        rd_val[slp_pkg::ST_SWAP] = cap_swap;
        rd_val[slp_pkg::ST_HOST] = cap_host;
        rd_val[slp_pkg::ST_VALID] = cap_valid;
      end
      slp_pkg::OFS_CHARGE:
      begin
        rd_val[4:0] = charge;
      end
      slp_pkg::OFS_HOSTCFG:
      begin
        rd_val[1:0] = host_cfg;
      end
      slp_pkg::OFS_PINOUT:
      begin
        rd_val[5:0] = pin_out;
      end
      slp_pkg::OFS_PORTS:
      begin
        rd_val[slp_pkg::PS_UP_LSB +: 5] = port_upstream_o;
        rd_val[slp_pkg::PS_EN_LSB +: 5] = port_enable_o;
        rd_val[slp_pkg::PS_OCS_LSB +: 5] = overcurrent_sense_en_o;
        rd_val[slp_pkg::PS_DCNT_LSB +: 3] = downstream_count_o;
      end
      default:
      begin
        rd_val = 32'h0;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      pready_o <= 1'b1;
      prdata_o <= pwrite_i ? 32'h0 : rd_val;
      pslverr_o <= ~reg_hit(paddr_i);
    end
    else
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end
  end

endmodule

// File: slp_board.sv
// Purpose: Board strap resistors.
// Assumes: One pull per strap pin.
// Notes: No pin is ever driven here.
`timescale 1ns/100ps
module slp_board
(
  input wire logic [5:0] pull_i,
  input wire logic [5:0] drive_i,
  input wire logic [5:0] oe_i,
  output logic [5:0] pin_o
);
  // ======
  // pulls where oe_i is low, drive_i where oe_i is high
  always_comb pin_o = (oe_i & drive_i) | (~oe_i & pull_i);
endmodule

// File: slp_chk_props.sv
// Purpose: Port checker of the strap latch.
// Assumes: Outputs follow the capture edge by two edges.
// Notes: Bound into every instance.
`timescale 1ns/100ps
module slp_chk
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic por_i,
  input wire logic ext_rst_n_i,
  input wire logic cfg_sda_i,
  input wire logic cfg_scl_i,
  input wire logic [5:0] strap_in_i,
  input wire logic [5:0] strap_oe_o,
  input wire logic [4:0] port_upstream_o,
  input wire logic [4:0] port_enable_o,
  input wire logic [4:0] overcurrent_sense_en_o,
  input wire logic [2:0] downstream_count_o,
  input wire logic [8:0] logical_port_phys_o,
  input wire logic [4:1] charge_advertise_o,
  input wire logic config_valid_o
);
  // ======
  // Capture
  logic [5:0] p1;
  logic [5:0] p2;
  wire hold = por_i | !ext_rst_n_i;
  wire cap = !hold && strap_oe_o == 6'h00;
  wire st = cap && !(cfg_sda_i && cfg_scl_i);
  always_ff @(posedge clk_i)
  begin
    p1 <= strap_in_i;
    p2 <= p1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ======
  // Properties
  a_hold_undriven:
    assert property (hold |=> strap_oe_o == 6'h00)
    else $error("pins driven in reset");
  a_drive_after:
    assert property (cap |=> strap_oe_o == 6'h3f)
    else $error("pins not driven");
  a_valid_rise:
    assert property (cap ##1 !hold |=> config_valid_o)
    else $error("no valid");
  a_mode_count:
    assert property (st |-> ##2 downstream_count_o == (p2[0] ? 3'h3 : 3'h4))
    else $error("bad count");
  a_up_pick:
    assert property (st |-> ##2 port_upstream_o == (p2[1] ? 5'h02 : 5'h01))
    else $error("bad upstream");
  a_port_enables:
    assert property (st |-> ##2 port_enable_o ==
      (!p2[0] ? 5'h1f : p2[1] ? 5'h1e : 5'h1d))
    else $error("bad enables");
  a_ocs_mask:
    assert property (st |-> ##2 overcurrent_sense_en_o ==
      (p2[1:0] == 2'h0 ? 5'h1e : 5'h1c))
    else $error("bad sensing");
  a_logical_map:
    assert property (config_valid_o |-> logical_port_phys_o == 9'h11a)
    else $error("bad map");
  a_charge_latch:
    assert property (st |-> ##2 charge_advertise_o == p2[5:2])
    else $error("bad charge");
  a_host_charge:
    assert property (cap && cfg_sda_i && cfg_scl_i |-> ##2
      charge_advertise_o == 4'h0)
    else $error("charge kept in host mode");
  a_roles_hold:
    assert property (config_valid_o && $past(config_valid_o) |->
      $stable(port_upstream_o) && $stable(port_enable_o))
    else $error("roles moved");
endmodule
bind slp_strap_latch slp_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .por_i(por_i), .ext_rst_n_i(ext_rst_n_i), .cfg_sda_i(cfg_sda_i),
  .cfg_scl_i(cfg_scl_i), .strap_in_i(strap_in_i), .strap_oe_o(strap_oe_o),
  .port_upstream_o(port_upstream_o), .port_enable_o(port_enable_o),
  .overcurrent_sense_en_o(overcurrent_sense_en_o),
  .downstream_count_o(downstream_count_o),
  .logical_port_phys_o(logical_port_phys_o),
  .charge_advertise_o(charge_advertise_o),
  .config_valid_o(config_valid_o));

// File: tb_top.sv
// Purpose: Bench for the strap latch.
// Assumes: Board pulls reach pins only while undriven.
// Notes: Each reset pulse is checked through ports and APB.
`timescale 1ns/100ps
module tb_top;
  logic clk_i, sys_rst_i, por_i, ext_rst_n_i, cfg_sda_i, cfg_scl_i;
  logic [5:0] strap_in_i, strap_out_o, strap_oe_o, pull;
  logic [7:0] paddr_i;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, config_valid_o, e;
  logic [31:0] pwdata_i, prdata_o, r;
  logic [4:0] port_upstream_o, port_enable_o, overcurrent_sense_en_o;
  logic [2:0] downstream_count_o;
  logic [8:0] logical_port_phys_o;
  logic [4:1] charge_advertise_o, c;
  int miscompares, checked, cyc, k;
  slp_strap_latch DUT (.*);
  slp_board u_board (.pull_i(pull), .drive_i(strap_out_o),
    .oe_i(strap_oe_o), .pin_o(strap_in_i));
  always #2 clk_i = ~clk_i;
  // ======
  // Tasks
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i);
    while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic strap_rst(input logic [5:0] p, input logic h,
    input logic pw);
    pull <= p;
    cfg_sda_i <= h;
    cfg_scl_i <= h;
    por_i <= pw;
    ext_rst_n_i <= pw;
    repeat (3) @(posedge clk_i);
    cmp(strap_oe_o, 6'h00);
    por_i <= 1'b0;
    ext_rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic chk(input logic m, s, h, input logic [3:0] ch,
    input logic [1:0] sm);
    logic [4:0] up, en, oc;
    logic [2:0] dc;
    up = s ? 5'h02 : 5'h01;
    en = !m ? 5'h1f : s ? 5'h1e : 5'h1d;
    oc = (!m && !s) ? 5'h1e : 5'h1c;
    dc = m ? 3'h3 : 3'h4;
    cmp(port_upstream_o, up);
    cmp(port_enable_o, en);
    cmp(overcurrent_sense_en_o, oc);
    cmp(logical_port_phys_o, 9'h11a);
    cmp(charge_advertise_o, ch);
    cmp(strap_oe_o, 6'h3f);
    cmp(config_valid_o, 1'b1);
    apb(1'b0, slp_pkg::OFS_PORTS, 32'h0);
    cmp(r, {13'h0, dc, 1'b0, oc, en, up});
    apb(1'b0, slp_pkg::OFS_STATUS, 32'h0);
    cmp(r, {28'h0, 1'b1, h, sm});
    apb(1'b0, slp_pkg::OFS_CHARGE, 32'h0);
    cmp(r, {27'h0, ch, 1'b0});
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  // ======
  // Sequence
  initial
  begin
    {clk_i, por_i, sys_rst_i, ext_rst_n_i} = 4'h7;
    {cfg_sda_i, cfg_scl_i, psel_i, penable_i, pwrite_i} = 5'h00;
    {pull, paddr_i, pwdata_i} = 46'h0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    por_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(1'b0, 1'b0, 1'b0, 4'h0, 2'h0);
    for (k = 0; k < 4; k++)
    begin
      c = 4'(4'h3 << k);
      strap_rst({c, k[1], k[0]}, 1'b0, k[0]);
      chk(k[0], k[1], 1'b0, c, {k[1], k[0]});
    end
    apb(1'b1, slp_pkg::OFS_STATUS, 32'hff);
    apb(1'b0, slp_pkg::OFS_STATUS, 32'h0);
    cmp(r, 32'hb);
    apb(1'b0, 8'h14, 32'h0);
    cmp(e, 1'b1);
    cmp(r, 32'h0);
    apb(1'b1, slp_pkg::OFS_PINOUT, 32'h2a);
    @(posedge clk_i);
    cmp(strap_in_i, 6'h2a);
    apb(1'b0, slp_pkg::OFS_STATUS, 32'h0);
    cmp(r, 32'hb);
    apb(1'b1, slp_pkg::OFS_HOSTCFG, 32'h3);
    strap_rst(6'h3c, 1'b1, 1'b0);
    chk(1'b1, 1'b1, 1'b1, 4'h0, 2'h0);
    cfg_sda_i <= 1'b0;
    pull <= 6'h05;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(1'b1, 1'b0, 1'b0, 4'h1, 2'h1);
    end_of_test();
  end
endmodule
